// [hw/spp_pin_sync.sv]
// Two-flop synchronisers for the serial pins plus clock edge detection
`timescale 1ns/10ps
module spp_pin_sync (
    input  wire logic  clk_sys_i,
    input  wire logic  rst_n_i,
    input  wire logic  sclk_i,
    input  wire logic  cs_n_i,
    input  wire logic  mosi_i,
    spp_edge_if.det    edge_o
);
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic       sclk_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // First stage is read only by the second stage
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            // Preset to the idle pin levels with the clock low, so no false clock edge follows reset while the idle clock is low
            meta_r   <= 3'h2;
            sync_r   <= 3'h2;
            sclk_d_r <= 1'b0;
        end else begin
            meta_r   <= {sclk_i, cs_n_i, mosi_i};
            sync_r   <= meta_r;
            sclk_d_r <= sync_r[2];
        end
    end

    // Edges from the settled clock level only
    assign edge_o.sclk_rise  = sync_r[2] & ~sclk_d_r;
    assign edge_o.sclk_fall  = ~sync_r[2] & sclk_d_r;
    assign edge_o.sel_active = ~sync_r[1];
    assign edge_o.mosi       = sync_r[0];
endmodule : spp_pin_sync

// [hw/spp_port.sv]
// Peripheral-role synchronous serial port, 16-bit words framed by chip select
`timescale 1ns/10ps
`include "spp_defs.svh"

// Summary of operation
// (R1) Peripheral role when controller-select bit is clear
// (R2) Clock and inbound data in, outbound data out
// (R3) Bit 16 selects clock phase
// (R4) Bit 17 selects idle clock polarity
// (R5) Prescale bits 15:8 bound host clock period
// (R6) Prescale zero: host period two system clocks
// (R7) Launch edge set by polarity xor phase
// (R8) Capture edge opposite the launch edge
// (R9) Host waits two clocks after select
// (R10) Host frames every 16-bit word separately
// (R11) Inactive select clears counter, releases output
module spp_port (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic [31:0]       serial_global_control_reg_i,
    input  wire logic [31:0]       frame_format_reg_i,
    input  wire logic              serial_clock_line_i,
    input  wire logic              cs_n_i,
    input  wire logic              ctrl_to_periph_data_i,
    input  wire spp_pkg::spp_word_t tx_word_i,
    output logic                   periph_to_ctrl_data_o,
    output logic                   periph_to_ctrl_data_oe_o,
    output spp_pkg::spp_word_t     rx_word_o,
    output logic                   rx_valid_o,
    output logic                   tx_taken_o,
    output logic                   sclk_too_fast_o
);
    import spp_pkg::*;

    spp_edge_if ev ();
    logic [4:0]  bit_cnt_r;
    spp_word_t   sh_rx_r;
    spp_word_t   sh_tx_r;
    logic        out_r;
    logic        oe_r;
    spp_word_t   rx_r;
    logic        rxv_r;
    logic        taken_r;
    logic [8:0]  per_cnt_r;
    logic        fast_r;
    logic        seen_edge_r;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation; data sees two flops of latency
    spp_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .sclk_i    (serial_clock_line_i),
        .cs_n_i    (cs_n_i),
        .mosi_i    (ctrl_to_periph_data_i),
        .edge_o    (ev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode
    wire       periph_en = ~serial_global_control_reg_i[`SPP_GCR_CTRL_SEL_BIT];   // R1
    wire       phase     = frame_format_reg_i[`SPP_FMT_PHASE_BIT];              // R3
    wire       pol       = frame_format_reg_i[`SPP_FMT_POL_BIT];                // R4
    spp_ps_t   ps;
    assign ps = frame_format_reg_i[`SPP_FMT_PS_HI:`SPP_FMT_PS_LO];              // R5
    // Launch on rise when polarity equals phase, capture on the other edge
    wire       launch_rise = (pol == phase);                                    // R7
    wire       launch_ev = launch_rise ? ev.sclk_rise : ev.sclk_fall;           // R7
    wire       cap_ev    = launch_rise ? ev.sclk_fall : ev.sclk_rise;           // R8
    wire       active    = periph_en & ev.sel_active;
    wire       last_bit  = (bit_cnt_r == 5'(`SPP_WORD_BITS - 1));
    // Minimum legal period in system clocks; zero prescale means exactly two
    wire [8:0] min_per   = (ps == 8'h00) ? 9'h002 : ({1'b0, ps} + 9'h001);      // R5 R6
    wire [8:0] ns_floor  = 9'(`SPP_MIN_SCLK_CYC);
    wire [8:0] need_per  = (min_per > ns_floor) ? min_per : ns_floor;
    // The MSB stands from select in every mode; a launch edge before the first capture is ignored
    wire       launch_ok = (bit_cnt_r != 5'h00);                                // R7

    ////////////////////////////////////////////////////////////////////////////
    // Shift engine; idle select reloads the word and releases the line
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 5'h00;
            sh_rx_r   <= `SPP_TX_RESET;
            sh_tx_r   <= `SPP_TX_RESET;
            out_r     <= 1'b0;
            oe_r      <= 1'b0;
            rx_r      <= `SPP_TX_RESET;
            rxv_r     <= 1'b0;
            taken_r   <= 1'b0;
        end else if (!active) begin
            bit_cnt_r <= 5'h00;                                                 // R11
            sh_tx_r   <= tx_word_i;
            out_r     <= tx_word_i[15];
            oe_r      <= 1'b0;                                                  // R11
            rxv_r     <= 1'b0;
            taken_r   <= 1'b0;
        end else begin
            oe_r    <= 1'b1;                                                    // R2
            rxv_r   <= 1'b0;
            taken_r <= 1'b0;
            if (launch_ev && launch_ok) begin
                out_r   <= sh_tx_r[14];                                         // R7
                sh_tx_r <= {sh_tx_r[14:0], 1'b0};
                if (bit_cnt_r == 5'h01) begin
                    taken_r <= 1'b1;
                end
            end
            if (cap_ev) begin
                sh_rx_r   <= {sh_rx_r[14:0], ev.mosi};                          // R8
                bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
                if (last_bit) begin
                    rx_r  <= {sh_rx_r[14:0], ev.mosi};                          // R10
                    rxv_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Period monitor: flags host clock faster than the prescale allows
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            per_cnt_r   <= 9'h000;
            fast_r      <= 1'b0;
            seen_edge_r <= 1'b0;
        end else if (!active) begin
            per_cnt_r   <= 9'h000;
            seen_edge_r <= 1'b0;
        end else if (ev.sclk_rise) begin
            per_cnt_r   <= 9'h001;
            seen_edge_r <= 1'b1;
            if (seen_edge_r && per_cnt_r < need_per) begin
                fast_r <= 1'b1;                                                 // R5 R6
            end
        end else if (per_cnt_r != 9'h1ff) begin
            per_cnt_r <= per_cnt_r + 9'h001;
        end
    end

    assign periph_to_ctrl_data_o    = out_r;
    assign periph_to_ctrl_data_oe_o = oe_r;
    assign rx_word_o                = rx_r;
    assign rx_valid_o               = rxv_r;
    assign tx_taken_o               = taken_r;
    assign sclk_too_fast_o          = fast_r;
endmodule : spp_port

// [inc/spp_defs.svh]
// Constants for the serial peripheral port: field positions, reset values and timing figures
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH

`define SPP_GCR_CTRL_SEL_BIT   0
`define SPP_FMT_PHASE_BIT      16
`define SPP_FMT_POL_BIT        17
`define SPP_FMT_PS_HI          15
`define SPP_FMT_PS_LO          8
`define SPP_WORD_BITS          16
`define SPP_MIN_SCLK_NS        25
`define SPP_SYS_PERIOD_NS      20
`define SPP_MIN_SCLK_CYC       ((`SPP_MIN_SCLK_NS + `SPP_SYS_PERIOD_NS - 1) / `SPP_SYS_PERIOD_NS)
`define SPP_TX_RESET           16'h0000

`endif

// [inc/spp_edge_if.sv]
// Synchronised serial pin levels and edge strobes between detector and shifter
`timescale 1ns/10ps
interface spp_edge_if;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_active;
    logic mosi;
    modport det (output sclk_rise, output sclk_fall, output sel_active, output mosi);
    modport use_side (input sclk_rise, input sclk_fall, input sel_active, input mosi);
endinterface : spp_edge_if

// [inc/spp_pkg.sv]
// Types shared by the serial peripheral port modules
package spp_pkg;
    typedef logic [15:0] spp_word_t;
    typedef logic [7:0]  spp_ps_t;
endpackage : spp_pkg

// [test/spp_host_model.sv]
// Behavioural host controller driving clock, select and inbound data
`timescale 1ns/10ps
module spp_host_model #(parameter int HALF = 8) (
    input  wire logic clk_sys_i,
    input  wire logic miso_i,
    input  wire logic oe_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Idle data line toggles so a stale bit never passes for a real one
    always @(posedge clk_sys_i) if (cs_n_o) mosi_o <= ~mosi_o;
    // One framed word; an undriven outbound line reads as unknown
    task automatic xfer(input logic [15:0] w, input logic pol, input logic pha, input int n,
                        output logic [15:0] got);
        got = 16'hxxxx;
        @(posedge clk_sys_i) sclk_o <= pol;
        repeat (2 * HALF) @(posedge clk_sys_i);
        cs_n_o <= 1'b0;
        repeat (4 * HALF) @(posedge clk_sys_i);
        for (int i = 15; i > 15 - n; i--) begin
            // Phase 1 captures on the leading edge, phase 0 on the trailing one
            if (pha) mosi_o <= w[i];
            repeat (HALF) @(posedge clk_sys_i);
            if (pha) got[i] = oe_i ? miso_i : 1'bx;
            sclk_o <= ~pol;
            if (!pha) mosi_o <= w[i];
            repeat (HALF) @(posedge clk_sys_i);
            if (!pha) got[i] = oe_i ? miso_i : 1'bx;
            sclk_o <= pol;
        end
        repeat (HALF) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        repeat (2 * HALF) @(posedge clk_sys_i);
    endtask : xfer
endmodule : spp_host_model

// [test/spp_monitor.sv]
// Pin-level checker for the serial peripheral port
`timescale 1ns/10ps
module spp_monitor (
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic [31:0]       serial_global_control_reg_i,
    input wire logic              serial_clock_line_i,
    input wire logic              cs_n_i,
    input wire logic              periph_to_ctrl_data_o,
    input wire logic              periph_to_ctrl_data_oe_o,
    input wire spp_pkg::spp_word_t rx_word_o,
    input wire logic              rx_valid_o,
    input wire logic              sclk_too_fast_o
);
    import spp_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Sync delay is three cycles, so idle conditions are held four before judging
    AST_IDLE_OFF: assert property (cs_n_i [*4] |-> !periph_to_ctrl_data_oe_o)
        else $error("data line driven while idle");
    AST_CTRL_OFF: assert property (serial_global_control_reg_i[0] [*4] |-> !periph_to_ctrl_data_oe_o)
        else $error("data line driven in controller role");
    AST_SEL_ON: assert property ((!cs_n_i && !serial_global_control_reg_i[0]) [*5] |-> periph_to_ctrl_data_oe_o)
        else $error("data line not driven while selected");
    AST_VALID_PULSE: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("word strobe longer than one cycle");
    AST_VALID_ROLE: assert property (rx_valid_o |-> !serial_global_control_reg_i[0])
        else $error("word received in controller role");
    AST_WORD_HOLD: assert property (!$stable(rx_word_o) |-> rx_valid_o)
        else $error("received word changed without strobe");
    AST_FAST_STICKY: assert property (sclk_too_fast_o |=> sclk_too_fast_o)
        else $error("clock rate flag cleared");
    // Output only moves after a pin edge; six quiet cycles cover the sync latency
    AST_OUT_QUIET: assert property (($stable(serial_clock_line_i) && $stable(cs_n_i)) [*6]
        |=> $stable(periph_to_ctrl_data_o) || !periph_to_ctrl_data_oe_o)
        else $error("outbound bit moved without clock edge");
endmodule : spp_monitor

// [test/tb_top.sv]
// Testbench: host transfers in every clock mode against the serial port
`timescale 1ns/10ps
module tb_top;
    import spp_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [31:0] gcr_r     = 32'h0;
    logic [31:0] fmt_r     = 32'h0000_0f00;
    spp_word_t   txw_r     = 16'h0;
    spp_word_t   got, rxw;
    logic        sclk, cs_n, mosi, miso, oe, rxv, fast;
    int          err_total = 0;
    int          checks_done = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    spp_port spp_port_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .serial_global_control_reg_i(gcr_r),
        .frame_format_reg_i(fmt_r), .serial_clock_line_i(sclk), .cs_n_i(cs_n), .ctrl_to_periph_data_i(mosi),
        .tx_word_i(txw_r), .periph_to_ctrl_data_o(miso), .periph_to_ctrl_data_oe_o(oe), .rx_word_o(rxw),
        .rx_valid_o(rxv), .tx_taken_o(), .sclk_too_fast_o(fast));
    spp_host_model spp_host_model_inst (.clk_sys_i(clk_sys_i), .miso_i(miso), .oe_i(oe), .sclk_o(sclk),
        .cs_n_o(cs_n), .mosi_o(mosi));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // Hang guard
    initial begin
        repeat (50000) @(posedge clk_sys_i);
        err_total++;
        complete_run();
    end
    // Main sequence; prescale 15 puts the 16-cycle host clock exactly on the limit
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check("oe after reset", {15'h0, oe}, 16'h0);
        for (int m = 0; m < 4; m++) begin
            fmt_r <= {14'h0, 2'(m), 16'h0f00};
            txw_r <= 16'(16'ha53c + m);
            @(posedge clk_sys_i);
            spp_host_model_inst.xfer(~txw_r, fmt_r[17], fmt_r[16], 16, got);
            check("outbound word", got, txw_r);
            check("inbound word", rxw, ~txw_r);
            check("rate flag", {15'h0, fast}, 16'h0);
        end
        fmt_r <= 32'h0000_0f00;
        @(posedge clk_sys_i);
        spp_host_model_inst.xfer(16'h00ff, 1'b0, 1'b0, 8, got);
        check("partial word", rxw, ~txw_r);
        spp_host_model_inst.xfer(16'h5a5a, 1'b0, 1'b0, 16, got);
        check("word after abort", rxw, 16'h5a5a);
        check("outbound after abort", got, txw_r);
        gcr_r <= 32'h1;
        spp_host_model_inst.xfer(16'h1234, 1'b0, 1'b0, 16, got);
        check("controller role rx", rxw, 16'h5a5a);
        check("controller role line", got, 16'hxxxx);
        gcr_r <= 32'h0;
        fmt_r <= 32'h0000_1000;
        spp_host_model_inst.xfer(16'h1234, 1'b0, 1'b0, 16, got);
        check("rate flag set", {15'h0, fast}, 16'h1);
        complete_run();
    end
endmodule : tb_top
bind spp_port spp_monitor spp_monitor_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .serial_global_control_reg_i(serial_global_control_reg_i), .serial_clock_line_i(serial_clock_line_i),
    .cs_n_i(cs_n_i), .periph_to_ctrl_data_o(periph_to_ctrl_data_o), .rx_word_o(rx_word_o),
    .periph_to_ctrl_data_oe_o(periph_to_ctrl_data_oe_o), .rx_valid_o(rx_valid_o), .sclk_too_fast_o(sclk_too_fast_o));
